/* File: core/tpc_pkg.sv */
package tpc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] TPC_OFS_CTRL = 8'h00;
  localparam logic [7:0] TPC_OFS_STEP = 8'h04;
  localparam logic [7:0] TPC_OFS_PATH = 8'h08;
  localparam logic [7:0] TPC_OFS_INTF = 8'h0c;
  localparam logic [7:0] TPC_OFS_CONST = 8'h10;
  localparam logic [7:0] TPC_OFS_TARGET = 8'h14;
  localparam logic [7:0] TPC_OFS_DELAY = 8'h18;
  localparam logic [7:0] TPC_OFS_STATUS = 8'h1c;
  localparam logic [7:0] TPC_OFS_PWR_RT = 8'h20;
  localparam logic [7:0] TPC_OFS_PWR_NRT = 8'h24;
  localparam logic [7:0] TPC_OFS_MINPWR = 8'h28;
  localparam logic [7:0] TPC_OFS_CODES = 8'h2c;

  // ==========================================================
  // ctrl fields
  localparam int TPC_CTRL_CLOSED = 0;
  localparam int TPC_CTRL_START = 1;

  // ==========================================================
  // power quantities in whole dB, signed dBm
  localparam int TPC_PW = 10;
  typedef logic signed [TPC_PW-1:0] tpc_pwr_t;
  localparam logic [1:0] TPC_STEP_MIN = 2'h1;
  localparam logic [1:0] TPC_STEP_MAX = 2'h3;
  localparam logic [1:0] TPC_STEP_RST = 2'h1;
  localparam tpc_pwr_t TPC_UL_RANGE = 10'sd80;
  localparam tpc_pwr_t TPC_DL_BALANCE = 10'sd20;
  localparam tpc_pwr_t TPC_MINPWR_RST = -10'sd50;
  localparam logic [2:0] TPC_DELAY_MIN = 3'h1;
  localparam logic [2:0] TPC_DELAY_MAX = 3'h7;
  localparam int TPC_NCODES = 4;

  // closed-loop cadence: at most 200 cycles per second
  localparam longint TPC_CLK_HZ = 100000000;
  localparam longint TPC_MAX_RATE_HZ = 200;
  localparam int TPC_MIN_GAP = int'(TPC_CLK_HZ / TPC_MAX_RATE_HZ);

  typedef enum logic [1:0] {
    TPC_ST_IDLE,
    TPC_ST_ACCESS,
    TPC_ST_OPEN,
    TPC_ST_CLOSED
  } tpc_state_e;
endpackage

/* File: core/tpc_cfg_if.sv */
`timescale 1ns/1ps
// configuration and status shared between bus slave and loop core
interface tpc_cfg_if;
  import tpc_pkg::*;
  logic closed_mode;
  logic start;
  logic [1:0] step;
  tpc_pwr_t path_loss;
  tpc_pwr_t intf_lvl;
  tpc_pwr_t l3_const;
  tpc_pwr_t target_sir;
  logic [2:0] ol_delay;
  tpc_pwr_t min_pwr;
  logic [TPC_NCODES-1:0] code_nrt;
  tpc_pwr_t pwr_rt;
  tpc_pwr_t pwr_nrt;
  tpc_state_e state;
  logic out_sync;
  logic tpc_tx;
  modport slave (
    output closed_mode, start, step, path_loss, intf_lvl, l3_const, target_sir,
    output ol_delay, min_pwr, code_nrt,
    input pwr_rt, pwr_nrt, state, out_sync, tpc_tx
  );
  modport core (
    input closed_mode, start, step, path_loss, intf_lvl, l3_const, target_sir,
    input ol_delay, min_pwr, code_nrt,
    output pwr_rt, pwr_nrt, state, out_sync, tpc_tx
  );
endinterface

/* File: core/tpc_axil.sv */
`timescale 1ns/1ps
module tpc_axil
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // block side
  tpc_cfg_if.slave cfg
);
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic wr_go;
  logic closed_q, start_q;
  logic [1:0] step_q;
  tpc_pwr_t path_q, intf_q, const_q, target_q, minp_q;
  logic [2:0] delay_q;
  logic [TPC_NCODES-1:0] nrt_q;
  logic [31:0] rd_d;
  logic rd_ok;

  assign s_awready = !aw_q && !s_bvalid;
  assign s_wready = !w_q && !s_bvalid;
  assign wr_go = aw_q && w_q && !s_bvalid;

  // ==========================================================
  // write path: address and data latched independently
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        wd_q <= s_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (awa_q <= TPC_OFS_CODES && awa_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // byte strobes are ignored: every field fits in the low byte pair
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      closed_q <= 1'b0;
      start_q <= 1'b0;
      step_q <= TPC_STEP_RST;
      path_q <= '0;
      intf_q <= '0;
      const_q <= '0;
      target_q <= '0;
      delay_q <= TPC_DELAY_MIN;
      minp_q <= TPC_MINPWR_RST;
      nrt_q <= '0;
    end else begin
      start_q <= 1'b0;
      if (wr_go) begin
        case (awa_q)
          TPC_OFS_CTRL: begin
            closed_q <= wd_q[TPC_CTRL_CLOSED];
            start_q <= wd_q[TPC_CTRL_START];
          end
          TPC_OFS_STEP: begin
            if (wd_q[1:0] < TPC_STEP_MIN) step_q <= TPC_STEP_MIN;
            else step_q <= wd_q[1:0];
          end
          TPC_OFS_PATH: path_q <= wd_q[TPC_PW-1:0];
          TPC_OFS_INTF: intf_q <= wd_q[TPC_PW-1:0];
          TPC_OFS_CONST: const_q <= wd_q[TPC_PW-1:0];
          TPC_OFS_TARGET: target_q <= wd_q[TPC_PW-1:0];
          TPC_OFS_DELAY: begin
            if (wd_q[2:0] < TPC_DELAY_MIN) delay_q <= TPC_DELAY_MIN;
            else delay_q <= wd_q[2:0];
          end
          TPC_OFS_MINPWR: minp_q <= wd_q[TPC_PW-1:0];
          TPC_OFS_CODES: nrt_q <= wd_q[TPC_NCODES-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  assign cfg.closed_mode = closed_q;
  assign cfg.start = start_q;
  assign cfg.step = step_q;
  assign cfg.path_loss = path_q;
  assign cfg.intf_lvl = intf_q;
  assign cfg.l3_const = const_q;
  assign cfg.target_sir = target_q;
  assign cfg.ol_delay = delay_q;
  assign cfg.min_pwr = minp_q;
  assign cfg.code_nrt = nrt_q;

  // ==========================================================
  // read path
  always_comb begin
    rd_d = 32'h0;
    rd_ok = 1'b1;
    case (s_araddr)
      TPC_OFS_CTRL: rd_d[TPC_CTRL_CLOSED] = closed_q;
      TPC_OFS_STEP: rd_d[1:0] = step_q;
      TPC_OFS_PATH: rd_d = {{(32-TPC_PW){path_q[TPC_PW-1]}}, path_q};
      TPC_OFS_INTF: rd_d = {{(32-TPC_PW){intf_q[TPC_PW-1]}}, intf_q};
      TPC_OFS_CONST: rd_d = {{(32-TPC_PW){const_q[TPC_PW-1]}}, const_q};
      TPC_OFS_TARGET: rd_d = {{(32-TPC_PW){target_q[TPC_PW-1]}}, target_q};
      TPC_OFS_DELAY: rd_d[2:0] = delay_q;
      TPC_OFS_STATUS: rd_d[3:0] = {cfg.tpc_tx, cfg.out_sync, cfg.state};
      TPC_OFS_PWR_RT: rd_d = {{(32-TPC_PW){cfg.pwr_rt[TPC_PW-1]}}, cfg.pwr_rt};
      TPC_OFS_PWR_NRT: rd_d = {{(32-TPC_PW){cfg.pwr_nrt[TPC_PW-1]}}, cfg.pwr_nrt};
      TPC_OFS_MINPWR: rd_d = {{(32-TPC_PW){minp_q[TPC_PW-1]}}, minp_q};
      TPC_OFS_CODES: rd_d[TPC_NCODES-1:0] = nrt_q;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_arready = !s_rvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_d;
      s_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule

/* File: core/tpc_top.sv */
`timescale 1ns/1ps
// Function
// - closed loop adjusts at most 200 per second
// - open-loop power applied 1..7 slots later
// - downlink code powers kept within 20 dB; the design applies this span to the uplink RT/NRT outputs instead
// - same-bearer codes share one power
// - RT and NRT each closed-loop, separate levels
// - access power is pathloss plus interference plus constant
// - start at access power, then open/closed
// - open loop uses access power formula
// - TPC 0 steps down, 1 steps up
// - target SIR set by outer loop
// - out of sync holds closed-loop power constant
// - out of sync sends TPC 1 continuously
// - UE sends TPC from downlink SIR compare
module tpc_top
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // timeslot strobe and sync status (from modem, asynchronous)
  input wire logic slot_tick,
  input wire logic in_sync,
  // received downlink tpc (soft value, positive means 1)
  input wire logic tpc_rx_valid,
  input wire logic tpc_rx_nrt,
  input wire logic signed [7:0] tpc_rx_soft,
  // downlink sir measurement
  input wire logic sir_valid,
  input wire logic signed [9:0] sir_meas,
  // uplink transmit power and tpc to send
  output tpc_pkg::tpc_pwr_t tx_pwr_rt,
  output tpc_pkg::tpc_pwr_t tx_pwr_nrt,
  output logic [tpc_pkg::TPC_NCODES-1:0] code_is_nrt,
  output logic tpc_tx_bit,
  output logic tpc_tx_strobe
);
  import tpc_pkg::*;

  tpc_cfg_if cfg ();

  tpc_axil u_axil (
    .mclk(mclk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .cfg(cfg.slave)
  );

  // ==========================================================
  // pin synchronisers; only the second stage is read
  logic [1:0] tick_s_q, sync_s_q;
  logic tick_old_q;
  logic slot_pulse;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_s_q <= 2'h0;
      sync_s_q <= 2'h0;
      tick_old_q <= 1'b0;
    end else begin
      tick_s_q <= {tick_s_q[0], slot_tick};
      sync_s_q <= {sync_s_q[0], in_sync};
      tick_old_q <= tick_s_q[1];
    end
  end
  assign slot_pulse = tick_s_q[1] && !tick_old_q;
  logic oos;
  assign oos = !sync_s_q[1];

  // ==========================================================
  // open-loop power with saturation
  tpc_pwr_t ol_pwr, max_pwr;
  logic signed [TPC_PW+1:0] ol_sum;
  assign max_pwr = cfg.min_pwr + TPC_UL_RANGE;
  assign ol_sum = 12'(cfg.path_loss) + 12'(cfg.intf_lvl) + 12'(cfg.l3_const);
  always_comb begin
    if (ol_sum > 12'(max_pwr)) ol_pwr = max_pwr;
    else if (ol_sum < 12'(cfg.min_pwr)) ol_pwr = cfg.min_pwr;
    else ol_pwr = ol_sum[TPC_PW-1:0];
  end

  // ==========================================================
  // open-loop delay line, one entry per slot
  tpc_pwr_t dly_q [TPC_DELAY_MAX+1];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i <= int'(TPC_DELAY_MAX); i++) dly_q[i] <= TPC_MINPWR_RST;
    end else if (slot_pulse) begin
      dly_q[0] <= ol_pwr;
      for (int i = 1; i <= int'(TPC_DELAY_MAX); i++) dly_q[i] <= dly_q[i-1];
    end
  end
  tpc_pwr_t ol_late;
  assign ol_late = dly_q[cfg.ol_delay - 3'h1];

  // ==========================================================
  // mode sequencing
  tpc_state_e st_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= TPC_ST_IDLE;
    end else begin
      case (st_q)
        TPC_ST_IDLE: if (cfg.start) st_q <= TPC_ST_ACCESS;
        TPC_ST_ACCESS: begin
          if (!oos) st_q <= cfg.closed_mode ? TPC_ST_CLOSED : TPC_ST_OPEN;
        end
        TPC_ST_OPEN: if (cfg.closed_mode) st_q <= TPC_ST_CLOSED;
        TPC_ST_CLOSED: if (!cfg.closed_mode) st_q <= TPC_ST_OPEN;
        default: st_q <= TPC_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // closed-loop rate limiter
  logic [$clog2(TPC_MIN_GAP+1)-1:0] gap_q;
  logic gap_ok;
  assign gap_ok = (gap_q == '0);
  logic cl_apply;
  assign cl_apply = (st_q == TPC_ST_CLOSED) && tpc_rx_valid && !oos && gap_ok;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gap_q <= '0;
    else if (cl_apply) gap_q <= ($bits(gap_q))'(TPC_MIN_GAP - 1);
    else if (!gap_ok) gap_q <= gap_q - 1'b1;
  end

  // ==========================================================
  // per-service power, one register each
  tpc_pwr_t pwr_q [2];
  tpc_pwr_t step_w;
  assign step_w = TPC_PW'(cfg.step);
  logic down;
  assign down = (tpc_rx_soft <= 8'sd0); // soft decision
  for (genvar s = 0; s < 2; s++) begin : g_svc
    tpc_pwr_t up_v, dn_v;
    assign up_v = (pwr_q[s] > max_pwr - step_w) ? max_pwr : pwr_q[s] + step_w;
    assign dn_v = (pwr_q[s] < cfg.min_pwr + step_w) ? cfg.min_pwr : pwr_q[s] - step_w;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        pwr_q[s] <= TPC_MINPWR_RST;
      end else begin
        case (st_q)
          TPC_ST_ACCESS: pwr_q[s] <= ol_pwr;
          TPC_ST_OPEN: if (slot_pulse) pwr_q[s] <= ol_late;
          TPC_ST_CLOSED: begin
            // per service; held while out of sync
            if (cl_apply && (tpc_rx_nrt == s[0])) pwr_q[s] <= down ? dn_v : up_v;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // uplink code powers, balanced within the downlink-style span
  tpc_pwr_t nrt_bal;
  always_comb begin
    if (pwr_q[1] < pwr_q[0] - TPC_DL_BALANCE) nrt_bal = pwr_q[0] - TPC_DL_BALANCE;
    else if (pwr_q[1] > pwr_q[0] + TPC_DL_BALANCE) nrt_bal = pwr_q[0] + TPC_DL_BALANCE;
    else nrt_bal = pwr_q[1];
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_pwr_rt <= TPC_MINPWR_RST;
      tx_pwr_nrt <= TPC_MINPWR_RST;
      code_is_nrt <= '0;
    end else begin
      tx_pwr_rt <= pwr_q[0];
      tx_pwr_nrt <= nrt_bal;
      code_is_nrt <= cfg.code_nrt;
    end
  end

  // ==========================================================
  // downlink tpc generation from sir compare
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tpc_tx_bit <= 1'b1;
      tpc_tx_strobe <= 1'b0;
    end else begin
      tpc_tx_strobe <= 1'b0;
      if (oos) begin
        // no measurement possible: a forced up command goes out once per slot,
        // and the bit only moves together with its strobe
        if (slot_pulse) begin
          tpc_tx_bit <= 1'b1;
          tpc_tx_strobe <= 1'b1;
        end
      end else if (sir_valid) begin
        tpc_tx_bit <= (sir_meas > cfg.target_sir) ? 1'b0 : 1'b1;
        tpc_tx_strobe <= 1'b1;
      end
    end
  end

  assign cfg.pwr_rt = pwr_q[0];
  assign cfg.pwr_nrt = pwr_q[1];
  assign cfg.state = st_q;
  assign cfg.out_sync = oos;
  assign cfg.tpc_tx = tpc_tx_bit;
endmodule

/* File: tb/tpc_top_chk.sv */
`timescale 1ns/1ps
module tpc_top_chk
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // loop signals
  input wire logic in_sync,
  input wire logic sir_valid,
  input wire tpc_pkg::tpc_pwr_t tx_pwr_rt,
  input wire tpc_pkg::tpc_pwr_t tx_pwr_nrt,
  input wire logic tpc_tx_bit,
  input wire logic tpc_tx_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // bus
  sequence wr_take_s;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_take_s;
    s_arvalid && s_arready;
  endsequence
  wr_answer_a: assert property (wr_take_s |-> ##2 s_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rd_take_s |=> s_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answer pending");
  // ==========================================================
  // loop
  // in_sync reaches the loop two edges late through its synchroniser
  sir_strobe_a: assert property (in_sync ##2 sir_valid |=> tpc_tx_strobe)
    else $error("no tpc after measurement");
  bit_hold_a: assert property ($changed(tpc_tx_bit) |-> tpc_tx_strobe)
    else $error("tpc bit moved without strobe");
  // synchroniser delay is covered by the four quiet cycles
  oos_up_a: assert property (!in_sync [*4] ##1 tpc_tx_strobe |-> tpc_tx_bit)
    else $error("tpc not up while unsynchronised");
  code_span_a: assert property ((tx_pwr_nrt - tx_pwr_rt) <= 20 && (tx_pwr_rt - tx_pwr_nrt) <= 20)
    else $error("code powers too far apart");
endmodule

bind tpc_top tpc_top_chk i_tpc_top_chk (
  .mclk(mclk), .rst(rst), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready), .in_sync(in_sync),
  .sir_valid(sir_valid), .tx_pwr_rt(tx_pwr_rt), .tx_pwr_nrt(tx_pwr_nrt),
  .tpc_tx_bit(tpc_tx_bit), .tpc_tx_strobe(tpc_tx_strobe)
);

/* File: tb/tpc_peer.sv */
`timescale 1ns/1ps
// far station: answers uplink sir with a soft tpc, follows our tpc downlink
module tpc_peer
  import tpc_pkg::*;
#(
  parameter int DL_INIT = 10
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench control
  input wire logic send,
  input wire logic signed [9:0] ul_sir,
  input wire logic signed [9:0] target,
  input wire logic [1:0] step,
  // air side
  input wire logic in_sync,
  input wire logic tpc_tx_bit,
  input wire logic tpc_tx_strobe,
  output logic tpc_rx_valid,
  output logic signed [7:0] tpc_rx_soft,
  output int dl_pwr
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tpc_rx_valid <= 1'b0;
      tpc_rx_soft <= 8'sh00;
      dl_pwr <= DL_INIT;
    end else begin
      tpc_rx_valid <= send;
      if (send) begin
        tpc_rx_soft <= (in_sync && ul_sir > target) ? -8'sd40 : 8'sd40;
      end else begin
        // never leave a stale soft value between bits
        tpc_rx_soft <= ~tpc_rx_soft;
      end
      if (tpc_tx_strobe && in_sync) begin
        dl_pwr <= tpc_tx_bit ? ((dl_pwr + step > 30) ? 30 : dl_pwr + step) :
          ((dl_pwr < step) ? 0 : dl_pwr - step);
      end
    end
  end
endmodule

/* File: tb/tpc_top_bench.sv */
`timescale 1ns/1ps
module tpc_top_bench;
  import tpc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd_d;
  logic [1:0] s_bresp, s_rresp, rd_r;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tpc_rx_valid;
  logic slot_tick = 1'b0, in_sync = 1'b0, tpc_rx_nrt = 1'b0, sir_valid = 1'b0, send = 1'b0;
  logic signed [9:0] sir_meas = 10'sh000, ul_sir = 10'sh000;
  logic signed [7:0] tpc_rx_soft;
  tpc_pwr_t tx_pwr_rt, tx_pwr_nrt;
  logic [TPC_NCODES-1:0] code_is_nrt;
  logic tpc_tx_bit, tpc_tx_strobe;
  int n_mismatch = 0, checks = 0, pm, pa, r, dl;
  always #5 mclk = ~mclk;

  tpc_top i_tpc_top (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .slot_tick(slot_tick),
    .in_sync(in_sync), .tpc_rx_valid(tpc_rx_valid), .tpc_rx_nrt(tpc_rx_nrt),
    .tpc_rx_soft(tpc_rx_soft), .sir_valid(sir_valid), .sir_meas(sir_meas),
    .tx_pwr_rt(tx_pwr_rt), .tx_pwr_nrt(tx_pwr_nrt), .code_is_nrt(code_is_nrt),
    .tpc_tx_bit(tpc_tx_bit), .tpc_tx_strobe(tpc_tx_strobe));
  tpc_peer i_tpc_peer (.mclk(mclk), .rst(rst), .send(send), .ul_sir(ul_sir),
    .target(10'sh00a), .step(2'h3), .in_sync(in_sync), .tpc_tx_bit(tpc_tx_bit),
    .tpc_tx_strobe(tpc_tx_strobe), .tpc_rx_valid(tpc_rx_valid),
    .tpc_rx_soft(tpc_rx_soft), .dl_pwr(dl));

  // ==========================================================
  // reporting
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      chk(1'b0, "timeout");
      end_of_test();
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // ==========================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      // accept one cycle late so the response must stand while unaccepted
      if (s_bvalid && !s_bready) s_bready <= 1'b1;
    end while (!(s_bvalid && s_bready) && n < 50);
    tmo(n);
    s_bready <= 1'b0;
    chk(s_bresp === 2'h0, "write response");
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && !s_rready) s_rready <= 1'b1;
    end while (!(s_rvalid && s_rready) && n < 50);
    tmo(n);
    rd_d = s_rdata;
    rd_r = s_rresp;
    s_rready <= 1'b0;
    @(posedge mclk);
  endtask

  // ==========================================================
  // loop stimulus
  task automatic sir(input int v, input logic e);
    int n;
    n = 0;
    sir_meas <= 10'(v);
    sir_valid <= 1'b1;
    @(posedge mclk);
    sir_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (!tpc_tx_strobe && n < 50);
    tmo(n);
    chk(tpc_tx_bit === e, "tpc bit");
  endtask
  task automatic tpc(input int s);
    ul_sir <= 10'(s);
    send <= 1'b1;
    @(posedge mclk);
    send <= 1'b0;
    tick(8);
  endtask
  task automatic slot(input int c);
    repeat (c) begin
      slot_tick <= 1'b1;
      tick(4);
      slot_tick <= 1'b0;
      tick(4);
    end
  endtask
  task automatic pw(input int e);
    chk(tx_pwr_rt === tpc_pwr_t'(e), "power");
  endtask

  initial begin
    void'($urandom(32'he8e5));
    tick(4);
    rst <= 1'b0;
    @(posedge mclk);
    pw(-50);
    chk(tpc_tx_bit === 1'b1, "reset tpc bit");
    rd(TPC_OFS_STEP);
    chk(rd_d[1:0] === 2'h1, "step reset");
    rd(8'h30);
    chk(rd_r === 2'h2, "unmapped read");
    wr(TPC_OFS_STEP, 32'h3);
    wr(TPC_OFS_TARGET, 32'ha);
    wr(TPC_OFS_CODES, 32'ha);
    chk(code_is_nrt === 4'ha, "code services");
    pa = 20 + int'($urandom % 20);
    wr(TPC_OFS_PATH, 32'(pa));
    wr(TPC_OFS_INTF, 32'(-20));
    wr(TPC_OFS_CONST, 32'(-5));
    wr(TPC_OFS_CTRL, 32'h3);
    tick(3);
    pm = pa - 25;
    pw(pm);
    wr(TPC_OFS_PATH, 32'h64);
    tick(3);
    pw(30);
    wr(TPC_OFS_PATH, 32'(pa));
    // unsynchronised: the command only leaves on a slot boundary
    fork
      slot(1);
      sir(50, 1'b1);
    join
    in_sync <= 1'b1;
    tick(6);
    rd(TPC_OFS_STATUS);
    chk(rd_d[1:0] === 2'h3, "closed loop state");
    in_sync <= 1'b0;
    tick(6);
    tpc(0);
    pw(pm);
    in_sync <= 1'b1;
    tick(6);
    r = int'($urandom % 40);
    tpc(r);
    pm = (r > 10) ? pm - 3 : pm + 3;
    pw(pm);
    tpc(40 - r);
    pw(pm);
    sir(50, 1'b0);
    sir(10, 1'b1);
    sir(-5, 1'b1);
    wr(TPC_OFS_TARGET, 32'(-10));
    sir(-5, 1'b0);
    wr(TPC_OFS_DELAY, 32'h3);
    // peer followed four synchronised commands: down, up, up, down
    chk(dl == 10 - 3 + 3 + 3 - 3, "downlink power");
    wr(TPC_OFS_CTRL, 32'h2);
    tick(3);
    // open loop only moves on a slot boundary
    pw(pm);
    rd(TPC_OFS_STATUS);
    chk(rd_d[1:0] === 2'h2, "open loop state");
    wr(TPC_OFS_PATH, 32'(pa + 10));
    slot(4);
    pw(pa - 15);
    // second reset in mid-run restarts the rate gap, so one more step fits
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    @(posedge mclk);
    pw(-50);
    wr(TPC_OFS_CTRL, 32'h3);
    tick(3);
    tpc_rx_nrt <= 1'b1;
    tpc(0);
    // access power is 0 + 0 + 0 after reset; only the nrt service steps up by 1
    pw(0);
    chk(tx_pwr_nrt === tpc_pwr_t'(1), "nrt power");
    end_of_test();
  end
endmodule
